// [include/sswc_pkg.sv]
// package for the suspend/sleep wake controller
package sswc_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [3:0] OFS_POWER_CONFIG = 4'h0;
   localparam logic [3:0] OFS_EXTRA_FLAG   = 4'h4;
   localparam logic [3:0] OFS_POWER_OPTION = 4'h8;
   localparam logic [3:0] OFS_MODE_STATUS  = 4'hc;
   // power_config_reg fields
   localparam int BIT_SLEEP   = 7;
   localparam int BIT_SUSPEND = 6;
   localparam int BIT_CLEAR   = 5;
   localparam int BIT_PIN_RESET_WAKE_FLAG   = 4;
   localparam int BIT_OSCFAIL = 3;
   localparam int BIT_ALARM   = 2;
   localparam int BIT_PMATCH  = 1;
   localparam int BIT_CMP     = 0;
   // extra_wake_flag_reg field
   localparam int BIT_CAPS    = 0;
   // power_option_reg fields
   localparam int BIT_WAKE_REQUEST_OUTPUT_ENABLE  = 6;
   localparam int BIT_SUPPLY_MONITOR_DISABLE  = 5;
   // index of each source in the five-wide event vector
   localparam int NSRC        = 5;
   localparam int SRC_CMP     = 0;
   localparam int SRC_PMATCH  = 1;
   localparam int SRC_ALARM   = 2;
   localparam int SRC_OSCFAIL = 3;
   localparam int SRC_CAPS    = 4;
   // timing
   localparam int FLAG_HOLD_CLKS = 2;
   localparam int CLK_HZ         = 10_000_000;
   localparam int WAKE_PULSE_NS  = 1000;
   localparam int WAKE_PULSE_CLKS = (WAKE_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // power mode state machine, gray along normal-suspend-wake path
   typedef enum logic [1:0]
   {
      MODE_RUN     = 2'b00,
      MODE_SUSPEND = 2'b01,
      MODE_WAKE    = 2'b11,
      MODE_SLEEP   = 2'b10
   } sswc_mode_t;
endpackage

// [include/sswc_flag_if.sv]
// interface carrying wake flags between controller and flag bank
`timescale 1ns/10ps
interface sswc_flag_if;
   logic [sswc_pkg::NSRC-1:0] event_v;
   logic                      clear;
   logic                      hold;
   logic [sswc_pkg::NSRC-1:0] flags;
   modport ctrl (output event_v, output clear, output hold, input flags);
   modport bank (input event_v, input clear, input hold, output flags);
endinterface

// [hw/sswc_flag_bank.sv]
// sticky wake flag bank
`timescale 1ns/10ps
module sswc_flag_bank
   import sswc_pkg::*;
(
   // clock and reset
   input  wire logic MCLK_IN,
   input  wire logic RST_IN,
   // flag carrier
   sswc_flag_if.bank fl
);
   logic [NSRC-1:0] flag_r;
   logic [NSRC-1:0] flag_nxt;

   // set wins over the clear; flags update even when not enabled
   always_comb
   begin
      flag_nxt = fl.clear ? '0 : flag_r;
      flag_nxt = flag_nxt | fl.event_v;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (RST_IN)
         flag_r <= '0;
      else
         flag_r <= flag_nxt;
   end

   // flags read zero for the first clocks after a suspend wake
   assign fl.flags = fl.hold ? '0 : flag_r;

   chk_set_beats_clear: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (fl.event_v != '0) |=> ((flag_r & $past(fl.event_v)) == $past(fl.event_v)))
      else $error("wake event lost");
endmodule

// [hw/sswc_top.sv]
// suspend and sleep wake controller with wishbone registers
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
module sswc_top
   import sswc_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK_IN,
   input  wire logic        RST_IN,
   // wishbone slave
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [3:0]  WB_ADR_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output logic      [31:0] WB_DAT_OUT,
   output logic             WB_ACK_OUT,
   // wake event sources as one-cycle pulses, the reset pin (wakes on its falling edge), and the pin reset input
   input  wire logic        CAPS_EVT_IN,
   input  wire logic        OSCFAIL_EVT_IN,
   input  wire logic        ALARM_EVT_IN,
   input  wire logic        PMATCH_EVT_IN,
   input  wire logic        CMP_RISE_IN,
   input  wire logic        RST_PIN_N_IN,
   input  wire logic        PIN_RESET_IN,
   // power control outputs
   output logic             SYSCLK_GATE_OUT,
   output logic             OSC_STOP_OUT,
   output logic             CORE_REG_OFF_OUT,
   output logic             RAM_ON_VDD_OUT,
   output logic             PIN_HOLD_OUT,
   output logic             CPU_HALT_OUT,
   output logic             MONITOR_OFF_OUT,
   output logic             FULL_POR_OUT,
   output logic             WAKE_REQ_N_OUT,
   output logic             WAKE_REQ_OE_OUT
);
   sswc_flag_if fl ();

   sswc_mode_t      mode_r,   mode_nxt;
   logic [NSRC-1:0] en_r,     en_nxt;
   logic            pin_reset_wake_flag_r,  pin_reset_wake_flag_nxt;
   logic            wake_request_output_enable_r, wake_request_output_enable_nxt;
   logic            supply_monitor_disable_r, supply_monitor_disable_nxt;
   logic [1:0]      hold_r,   hold_nxt;
   logic [3:0]      wreq_r,   wreq_nxt;
   logic            pin_q_r;
   logic            ack_r,    ack_nxt;
   logic [31:0]     rdat_r,   rdat_nxt;
   logic            por_r,    por_nxt;

   logic            wb_req;
   logic            wr_cfg;
   logic            pin_fall;
   logic [NSRC-1:0] evt;
   logic [NSRC-1:0] wake_mask;
   logic            wake_now;
   logic [NSRC-1:0] cfg_en;
   logic            entry_ok;

   // the wake pulse counter is four bits wide
   if (WAKE_PULSE_CLKS < 1 || WAKE_PULSE_CLKS > 15)
   begin : g_bad_pulse
      $error("wake pulse count out of range");
   end

   sswc_flag_bank u_bank
   (
      .MCLK_IN (MCLK_IN),
      .RST_IN  (RST_IN),
      .fl      (fl)
   );

   assign wb_req   = WB_CYC_IN && WB_STB_IN && !ack_r;
   assign wr_cfg   = wb_req && WB_WE_IN && WB_SEL_IN[0] && (WB_ADR_IN == OFS_POWER_CONFIG);
   assign pin_fall = pin_q_r && !RST_PIN_N_IN;
   assign evt      = {CAPS_EVT_IN, OSCFAIL_EVT_IN, ALARM_EVT_IN, PMATCH_EVT_IN, CMP_RISE_IN};
   // cap sense only counts in suspend
   assign wake_mask = (mode_r == MODE_SLEEP) ? (en_r & ~(NSRC'(1) << SRC_CAPS)) : en_r;
   assign wake_now  = ((evt & wake_mask) != '0) || pin_fall;
   assign cfg_en    = {en_r[SRC_CAPS], WB_DAT_IN[BIT_OSCFAIL:BIT_CMP]};
   // set flags of the sources this write enables, or of an enabled cap sense, block entry, as does the pin reset flag
   assign entry_ok  = ((fl.flags & cfg_en) == '0) && !pin_reset_wake_flag_r;

   assign fl.event_v = evt;
   assign fl.clear   = wr_cfg && WB_DAT_IN[BIT_CLEAR];
   assign fl.hold    = hold_r != 2'b00;

   always_comb
   begin
      mode_nxt   = mode_r;
      en_nxt     = en_r;
      pin_reset_wake_flag_nxt  = pin_reset_wake_flag_r | pin_fall;
      wake_request_output_enable_nxt = wake_request_output_enable_r;
      supply_monitor_disable_nxt = supply_monitor_disable_r;
      hold_nxt   = (hold_r != 2'b00) ? hold_r - 2'b01 : 2'b00;
      wreq_nxt   = (wreq_r != 4'h0) ? wreq_r - 4'h1 : 4'h0;
      por_nxt    = PIN_RESET_IN && supply_monitor_disable_r;
      ack_nxt    = wb_req;
      rdat_nxt   = 32'h0;
      if (fl.clear)
         pin_reset_wake_flag_nxt = pin_fall;
      if (wb_req && WB_WE_IN && WB_SEL_IN[0])
      begin
         case (WB_ADR_IN)
            OFS_POWER_CONFIG: en_nxt[SRC_OSCFAIL:SRC_CMP] = WB_DAT_IN[BIT_OSCFAIL:BIT_CMP];
            OFS_EXTRA_FLAG:   en_nxt[SRC_CAPS] = WB_DAT_IN[BIT_CAPS];
            OFS_POWER_OPTION:
            begin
               wake_request_output_enable_nxt = WB_DAT_IN[BIT_WAKE_REQUEST_OUTPUT_ENABLE];
               supply_monitor_disable_nxt = WB_DAT_IN[BIT_SUPPLY_MONITOR_DISABLE];
            end
            default: ;
         endcase
      end
      // a reset with the monitor off outranks a write in the same cycle
      if (PIN_RESET_IN && supply_monitor_disable_r)
         supply_monitor_disable_nxt = 1'b0;
      if (wb_req && !WB_WE_IN)
      begin
         case (WB_ADR_IN)
            OFS_POWER_CONFIG: rdat_nxt[7:0] = {3'b000, pin_reset_wake_flag_r && !fl.hold, fl.flags[SRC_OSCFAIL:SRC_CMP]};
            OFS_EXTRA_FLAG:   rdat_nxt[7:0] = {7'h00, fl.flags[SRC_CAPS]};
            OFS_POWER_OPTION: rdat_nxt[7:0] = {1'b0, wake_request_output_enable_r, supply_monitor_disable_r, 5'h00};
            OFS_MODE_STATUS:  rdat_nxt[7:0] = {6'h00, mode_r};
            default:          rdat_nxt = 32'h0;
         endcase
      end
      case (mode_r)
         MODE_RUN:
         begin
            if (wr_cfg && entry_ok && WB_DAT_IN[BIT_SLEEP])
               mode_nxt = MODE_SLEEP;
            else if (wr_cfg && entry_ok && WB_DAT_IN[BIT_SUSPEND])
               mode_nxt = MODE_SUSPEND;
         end
         MODE_SUSPEND:
         begin
            if (wake_now)
            begin
               mode_nxt = MODE_WAKE;
               hold_nxt = 2'(FLAG_HOLD_CLKS);
            end
         end
         MODE_WAKE:
            mode_nxt = MODE_RUN;
         MODE_SLEEP:
         begin
            if (wake_now)
            begin
               mode_nxt = MODE_RUN;
               wreq_nxt = 4'(WAKE_PULSE_CLKS);
            end
         end
         default: mode_nxt = MODE_RUN;
      endcase
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (RST_IN)
      begin
         mode_r   <= MODE_RUN;
         en_r     <= '0;
         pin_reset_wake_flag_r  <= 1'b0;
         wake_request_output_enable_r <= 1'b0;
         supply_monitor_disable_r <= 1'b0;
         hold_r   <= 2'b00;
         wreq_r   <= 4'h0;
         pin_q_r  <= 1'b1;
         ack_r    <= 1'b0;
         rdat_r   <= 32'h0;
         por_r    <= 1'b0;
      end
      else
      begin
         mode_r   <= mode_nxt;
         en_r     <= en_nxt;
         pin_reset_wake_flag_r  <= pin_reset_wake_flag_nxt;
         wake_request_output_enable_r <= wake_request_output_enable_nxt;
         supply_monitor_disable_r <= supply_monitor_disable_nxt;
         hold_r   <= hold_nxt;
         wreq_r   <= wreq_nxt;
         pin_q_r  <= RST_PIN_N_IN;
         ack_r    <= ack_nxt;
         rdat_r   <= rdat_nxt;
         por_r    <= por_nxt;
      end
   end

   // suspend and sleep both stop the clock; sleep also drops the core supply
   assign SYSCLK_GATE_OUT  = (mode_r == MODE_SUSPEND) || (mode_r == MODE_SLEEP);
   assign OSC_STOP_OUT     = SYSCLK_GATE_OUT;
   assign CPU_HALT_OUT     = SYSCLK_GATE_OUT;
   assign CORE_REG_OFF_OUT = (mode_r == MODE_SLEEP);
   assign RAM_ON_VDD_OUT   = (mode_r == MODE_SLEEP);
   // pad latches keep output values and input buffers alive in sleep
   assign PIN_HOLD_OUT     = (mode_r == MODE_SLEEP);
   assign MONITOR_OFF_OUT  = supply_monitor_disable_r;
   assign FULL_POR_OUT     = por_r;
   assign WAKE_REQ_N_OUT   = !(wreq_r != 4'h0);
   assign WAKE_REQ_OE_OUT  = wake_request_output_enable_r;
   assign WB_ACK_OUT       = ack_r;
   assign WB_DAT_OUT       = rdat_r;

   chk_flags_hidden: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (mode_r == MODE_SUSPEND && wake_now) |=> (fl.flags == '0) [*2])
      else $error("flags visible too soon after suspend wake");
   chk_wake_low: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (mode_r == MODE_SLEEP && wake_now) |=> !WAKE_REQ_N_OUT && mode_r == MODE_RUN)
      else $error("wake request not driven on sleep exit");
   chk_caps_no_sleep: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (mode_r == MODE_SLEEP && evt == (NSRC'(1) << SRC_CAPS) && RST_PIN_N_IN && pin_q_r) |=> mode_r == MODE_SLEEP)
      else $error("cap sense woke from sleep");
   chk_pin_wake: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (SYSCLK_GATE_OUT && pin_fall) |=> !SYSCLK_GATE_OUT ##0 pin_reset_wake_flag_r)
      else $error("reset pin edge did not wake");
   chk_entry_block: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (mode_r == MODE_RUN && wr_cfg && !entry_ok) |=> mode_r == MODE_RUN)
      else $error("entered low power with flag set");
   chk_suspend_gate: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (mode_r == MODE_RUN && wr_cfg && entry_ok && WB_DAT_IN[BIT_SUSPEND] && !WB_DAT_IN[BIT_SLEEP])
      |=> SYSCLK_GATE_OUT && OSC_STOP_OUT && !CORE_REG_OFF_OUT)
      else $error("suspend did not gate clock");
   chk_sleep_power: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      CORE_REG_OFF_OUT |-> RAM_ON_VDD_OUT && PIN_HOLD_OUT && mode_r == MODE_SLEEP)
      else $error("sleep power state inconsistent");
   chk_supply_monitor_disable_por: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (PIN_RESET_IN && supply_monitor_disable_r) |=> FULL_POR_OUT && !MONITOR_OFF_OUT)
      else $error("reset with monitor off gave no full por");
   chk_clear_all: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (fl.clear && evt == '0 && !pin_fall) |=> ##2 (fl.flags == '0 || $past(evt) != '0 || $past(evt, 2) != '0))
      else $error("flag clear left flags set");
endmodule

// [bench/sswc_wake_model.sv]
// wake event sources and reset pin seen by the controller
`timescale 1ns/10ps
module sswc_wake_model
   import sswc_pkg::*;
(
   // clock
   input  wire logic       MCLK_IN,
   // request from bench: bits 4:0 sources, bit 5 reset pin glitch
   input  wire logic [5:0] fire_in,
   input  wire logic [7:0] delay_in,
   // toward the controller
   output logic      [4:0] evt_out,
   output logic            rst_pin_n_out
);
   logic [5:0] pend_r = 6'h00;
   logic [7:0] cnt_r  = 8'h00;
   initial evt_out = 5'h00;
   // pin idles high through its pull-up
   initial rst_pin_n_out = 1'b1;
   // a held request answers promptly or after delay_in cycles, as a one-cycle pulse
   always @(posedge MCLK_IN)
   begin
      evt_out       <= 5'h00;
      rst_pin_n_out <= 1'b1;
      if (fire_in != 6'h00)
      begin
         pend_r <= fire_in;
         cnt_r  <= delay_in;
      end
      else if (pend_r != 6'h00)
      begin
         if (cnt_r == 8'h00)
         begin
            evt_out       <= pend_r[4:0];
            rst_pin_n_out <= ~pend_r[5];
            pend_r        <= 6'h00;
         end
         else
            cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule

// [bench/test_suspend_sleep_wake_control.sv]
// self-checking bench for the suspend and sleep wake controller
`timescale 1ns/10ps
module test_suspend_sleep_wake_control;
   import sswc_pkg::*;
   logic        MCLK_IN = 1'b0, RST_IN = 1'b1, PIN_RESET_IN = 1'b0;
   logic        WB_CYC_IN = 1'b0, WB_STB_IN = 1'b0, WB_WE_IN = 1'b0;
   logic [3:0]  WB_ADR_IN = 4'h0, WB_SEL_IN = 4'hf;
   logic [31:0] WB_DAT_IN = 32'h0, WB_DAT_OUT;
   logic        WB_ACK_OUT, SYSCLK_GATE_OUT, OSC_STOP_OUT, CORE_REG_OFF_OUT, RAM_ON_VDD_OUT, PIN_HOLD_OUT;
   logic        CPU_HALT_OUT, MONITOR_OFF_OUT, FULL_POR_OUT, WAKE_REQ_N_OUT, WAKE_REQ_OE_OUT, pin_n;
   logic [4:0]  evt;
   logic [5:0]  fire_r = 6'h00;
   logic [7:0]  dly_r = 8'h00;
   int          error_cnt = 0, comparisons = 0, cyc_cnt = 0;

   sswc_wake_model i_model (.MCLK_IN(MCLK_IN), .fire_in(fire_r), .delay_in(dly_r), .evt_out(evt),
      .rst_pin_n_out(pin_n));
   sswc_top i_dut (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
      .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
      .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .CAPS_EVT_IN(evt[SRC_CAPS]),
      .OSCFAIL_EVT_IN(evt[SRC_OSCFAIL]), .ALARM_EVT_IN(evt[SRC_ALARM]), .PMATCH_EVT_IN(evt[SRC_PMATCH]),
      .CMP_RISE_IN(evt[SRC_CMP]), .RST_PIN_N_IN(pin_n), .PIN_RESET_IN(PIN_RESET_IN),
      .SYSCLK_GATE_OUT(SYSCLK_GATE_OUT), .OSC_STOP_OUT(OSC_STOP_OUT), .CORE_REG_OFF_OUT(CORE_REG_OFF_OUT),
      .RAM_ON_VDD_OUT(RAM_ON_VDD_OUT), .PIN_HOLD_OUT(PIN_HOLD_OUT), .CPU_HALT_OUT(CPU_HALT_OUT),
      .MONITOR_OFF_OUT(MONITOR_OFF_OUT), .FULL_POR_OUT(FULL_POR_OUT), .WAKE_REQ_N_OUT(WAKE_REQ_N_OUT),
      .WAKE_REQ_OE_OUT(WAKE_REQ_OE_OUT));

   initial forever #50 MCLK_IN = ~MCLK_IN;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one classic cycle; the task waits for the ack and checks that it comes one cycle after the strobe
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      WB_CYC_IN <= 1'b1;
      WB_STB_IN <= 1'b1;
      WB_WE_IN  <= w;
      WB_ADR_IN <= a;
      WB_DAT_IN <= {24'h0, d};
      @(posedge MCLK_IN);
      // no limit here: only the bench ceiling ends a hung cycle
      while (WB_ACK_OUT !== 1'b1)
      begin
         @(posedge MCLK_IN);
         n++;
      end
      q = WB_DAT_OUT;
      chk("ack latency", n, 32'd1);
      WB_CYC_IN <= 1'b0;
      WB_STB_IN <= 1'b0;
      @(posedge MCLK_IN);
   endtask

   task automatic fire(input logic [5:0] v, input logic [7:0] d);
      fire_r <= v;
      dly_r  <= d;
      @(posedge MCLK_IN);
      fire_r <= 6'h00;
   endtask

   task automatic wait_mode(input logic [31:0] e);
      logic [31:0] q;
      int          n;
      n = 0;
      do
      begin
         wb(1'b0, OFS_MODE_STATUS, 8'h00, q);
         n++;
      end
      while (q !== e && n < 30);
      chk("mode", q, e);
   endtask

   task automatic t_reset();
      logic [31:0] q;
      for (int a = 0; a < 14; a += 2)
      begin
         wb(1'b0, a[3:0], 8'h00, q);
         chk("reset read", q, 32'h0);
      end
      chk("idle outputs", {SYSCLK_GATE_OUT, CORE_REG_OFF_OUT, MONITOR_OFF_OUT, WAKE_REQ_N_OUT}, 4'b0001);
      $display("reset test done");
   endtask

   // source i: 0..4 as event index, 5 reset pin glitch
   task automatic t_wake(input int i, input bit slp);
      logic [31:0] q;
      logic [7:0]  en;
      en = (i < 4) ? 8'h01 << i : 8'h00;
      wb(1'b1, OFS_POWER_CONFIG, 8'h20, q);
      wb(1'b1, OFS_EXTRA_FLAG, {7'h0, i == 4}, q);
      // clock source is taken as already on the low power oscillator
      wb(1'b1, OFS_POWER_CONFIG, en | (slp ? 8'h80 : 8'h40), q);
      wb(1'b0, OFS_MODE_STATUS, 8'h00, q);
      chk("mode entry", q, slp ? 32'h2 : 32'h1);
      chk("clock stop", {SYSCLK_GATE_OUT, OSC_STOP_OUT, CPU_HALT_OUT}, 3'b111);
      chk("sleep power", {CORE_REG_OFF_OUT, RAM_ON_VDD_OUT, PIN_HOLD_OUT}, slp ? 3'b111 : 3'b000);
      fire(6'h01 << i, 8'd3);
      if (slp && i == 4)
      begin
         repeat (10) @(posedge MCLK_IN);
         wait_mode(32'h2);
         fire(6'h20, 8'd0);
      end
      wait_mode(32'h0);
      chk("clock run", SYSCLK_GATE_OUT, 1'b0);
      wb(1'b0, OFS_POWER_CONFIG, 8'h00, q);
      chk("wake flags", q, (i == 5 || (slp && i == 4)) ? 32'h10 : en);
      wb(1'b0, OFS_EXTRA_FLAG, 8'h00, q);
      chk("cap flag", q, i == 4);
      // after a pin wake the reset must get time before the next entry
      repeat (150) @(posedge MCLK_IN);
      $display("wake test done source %0d sleep %0d", i, slp);
   endtask

   task automatic t_refuse();
      logic [31:0] q;
      wb(1'b1, OFS_POWER_CONFIG, 8'h20, q);
      fire(6'h04, 8'd0);
      repeat (4) @(posedge MCLK_IN);
      wb(1'b0, OFS_POWER_CONFIG, 8'h00, q);
      chk("flag not enabled", q, 32'h4);
      wb(1'b1, OFS_POWER_CONFIG, 8'h44, q);
      wb(1'b0, OFS_MODE_STATUS, 8'h00, q);
      chk("entry refused", q, 32'h0);
      wb(1'b1, OFS_POWER_CONFIG, 8'h41, q);
      wb(1'b0, OFS_MODE_STATUS, 8'h00, q);
      chk("entry allowed", q, 32'h1);
      fire(6'h01, 8'd0);
      wait_mode(32'h0);
      $display("refusal test done");
   endtask

   task automatic t_wakeout();
      logic [31:0] q;
      int          n;
      wb(1'b1, OFS_POWER_OPTION, 8'h40, q);
      chk("wake oe", WAKE_REQ_OE_OUT, 1'b1);
      wb(1'b1, OFS_POWER_CONFIG, 8'h20, q);
      wb(1'b1, OFS_POWER_CONFIG, 8'h81, q);
      n = 0;
      fire(6'h01, 8'd3);
      repeat (40)
      begin
         @(posedge MCLK_IN);
         if (WAKE_REQ_N_OUT === 1'b0)
            n++;
      end
      chk("wake pulse", n, WAKE_PULSE_CLKS);
      wait_mode(32'h0);
      $display("wake output test done");
   endtask

   task automatic t_monitor();
      logic [31:0] q;
      wb(1'b1, OFS_POWER_OPTION, 8'h20, q);
      chk("monitor off", MONITOR_OFF_OUT, 1'b1);
      PIN_RESET_IN <= 1'b1;
      @(posedge MCLK_IN);
      PIN_RESET_IN <= 1'b0;
      #1 chk("full por", FULL_POR_OUT, 1'b1);
      repeat (10) @(posedge MCLK_IN);
      chk("monitor back", MONITOR_OFF_OUT, 1'b0);
      chk("por pulse end", FULL_POR_OUT, 1'b0);
      $display("monitor test done");
   endtask

   // ceiling well above the roughly 2300 cycles the tests need
   always @(posedge MCLK_IN)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (2) @(posedge MCLK_IN);
      RST_IN <= 1'b0;
      t_reset();
      for (int i = 0; i < 6; i++)
      begin
         t_wake(i, 1'b0);
         t_wake(i, 1'b1);
      end
      t_refuse();
      t_wakeout();
      t_monitor();
      tally_and_finish();
   end
endmodule
